// file: core/adc_q2_control.sv
// queue 2 control register, queue 2 sequencing and queue 1 boundary
// assumes the engine raises q1_active in the cycle of q1_trigger and that
// all engine strobes are on clk; ext_trigger_pin is asynchronous
//
// Notes on behaviour
// - without a prior pause, restart suspends from the queue's first word.
// - after a pause, restart suspends from the current subqueue's first word.
// - a finished subqueue is not rerun until the whole queue is done.
// - a queue 1 trigger suspends queue 2; it resumes later.
// - resume bit 7 set continues at the aborted word; clear restarts.
// - resume bit changes apply only at queue start, end of queue, mode change or stop mode.
// - bits 6..0 give queue 2 start and queue 1 end boundary.
// - start pointer 64 or more empties queue 2; queue 1 ends at word 63.
// - start pointer 0 stops queue 1 after reading word 0, no conversion.
// - pointer writes after start or while pending wait for next start.
// - continuous mode retriggers at end, restarting at the live pointer.
// - pointer changes act at once as the queue 1 boundary.
// - a word in conversion finishes before a moved boundary applies.
// - each queue 1 fetch is compared with the pointer; match ends queue 1.
// - stop mode resets the control register to 0x007F.
// - completion interrupt on last word done when bit 15 is set.
// - pause interrupt on paused word done when bit 14 is set.
// - bit 13 gates triggers in single-scan modes.
// - single-scan enable reads zero outside test mode, self-clears at end.
// - single-scan enable and single-scan mode may be written together.
// - bits 12..8 select the queue 2 operating mode.
// - mode codes as listed; 01111, 10000 and 11111 are reserved.
// - timer modes trigger every clock times 2^7 up to 2^17.
// - a queue also ends on channel 63 or the last table word.
//
// Decided for this implementation: the register addresses and the strobed register port.
`timescale 1ns/10ps
module adc_q2_control
  import adc_q2_pkg::*;
#(
  parameter int TIMER_EXP_BASE = TIMER_EXP_MIN
) (
  input  wire logic         clk,
  input  wire logic         rst_n,
  input  wire logic         stop_mode,
  input  wire logic         test_mode,
  input  wire logic [3:0]   reg_addr,
  input  wire logic [15:0]  reg_wdata,
  input  wire logic         reg_wr,
  input  wire logic         reg_rd,
  output logic [15:0]       reg_rdata,
  input  wire logic         ext_trigger_pin,
  input  wire logic         q1_trigger,
  input  wire logic         q1_active,
  input  wire logic         q1_fetch,
  input  wire logic [6:0]   q1_fetch_loc,
  input  wire logic         q1_conv_done,
  input  wire conv_result_t q2_result,
  output logic              q2_run,
  output logic [6:0]        q2_cmd_ptr,
  output logic              q2_complete_irq,
  output logic              q2_pause_irq,
  output logic              q1_end,
  output logic              q1_abort
);
  q2_ctrl_t   ctrl_reg;
  q2_ctrl_t   wr_val;
  q2_state_t  state_reg;
  logic [6:0] sub_start_reg;
  logic       resume_lat_reg;
  logic [1:0] retrig_cnt_reg;
  logic [2:0] ext_sync_reg;
  logic       ext_level_reg;
  logic       ctrl_wr;
  logic       mode_change;
  logic       sse_clear;
  logic       ext_stable;
  logic       ext_rise;
  logic       ext_fall;
  logic       timer_tick;
  logic       single;
  logic       sw_mode;
  logic       edge_trig;
  logic       start_req;
  logic       q2_empty;
  logic       conv_taken;
  logic       last_word;
  logic       cont_restart;

  assign wr_val      = q2_ctrl_t'(reg_wdata);
  assign ctrl_wr     = reg_wr && reg_addr == ADDR_Q2_CTRL;
  assign mode_change = ctrl_wr && wr_val.mode != ctrl_reg.mode;

  // control register
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_reg <= q2_ctrl_t'(CTRL_RESET);
    end else if (stop_mode) begin
      ctrl_reg <= q2_ctrl_t'(CTRL_RESET);
    end else if (ctrl_wr) begin
      // a written one beats the self-clear of the same cycle
      ctrl_reg <= wr_val;
    end else if (sse_clear) begin
      ctrl_reg.sse <= 1'b0;
    end
  end

  // read port, data in the cycle after the strobe
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      reg_rdata <= '0;
    end else if (reg_rd && reg_addr == ADDR_Q2_CTRL) begin
      reg_rdata                 <= ctrl_reg;
      reg_rdata[CTRL_SSE_BIT]   <= ctrl_reg.sse && test_mode;
    end else if (reg_rd && reg_addr == ADDR_Q2_STATUS) begin
      reg_rdata                 <= '0;
      reg_rdata[STAT_STATE_LO+:3] <= state_reg;
      reg_rdata[STAT_PTR_LO+:7]   <= q2_cmd_ptr;
    end else begin
      reg_rdata <= '0;
    end
  end

  // external trigger pin: three stages, a change counts once stages two and three agree
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ext_sync_reg <= '0;
    end else begin
      ext_sync_reg <= {ext_sync_reg[1:0], ext_trigger_pin};
    end
  end

  assign ext_stable = ext_sync_reg[1] == ext_sync_reg[2];
  assign ext_rise   = ext_stable && ext_sync_reg[2] && !ext_level_reg;
  assign ext_fall   = ext_stable && !ext_sync_reg[2] && ext_level_reg;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ext_level_reg <= 1'b0;
    end else if (ext_stable) begin
      ext_level_reg <= ext_sync_reg[2];
    end
  end

  q2_interval_timer #(
    .EXP_BASE (TIMER_EXP_BASE)
  ) u_timer (
    .clk     (clk),
    .rst_n   (rst_n),
    .mode    (ctrl_reg.mode),
    .restart (mode_change || stop_mode),
    .tick    (timer_tick)
  );

  // trigger qualification
  assign single    = !ctrl_reg.mode[MODE_CONT_BIT];
  assign sw_mode   = ctrl_reg.mode[3:0] == MODE_LOW_SW;
  assign q2_empty  = ctrl_reg.start_ptr[6];
  assign edge_trig = (ctrl_reg.mode[3:0] == MODE_LOW_RISE && ext_rise)
                  || (ctrl_reg.mode[3:0] == MODE_LOW_FALL && ext_fall)
                  || (mode_timer(ctrl_reg.mode) && timer_tick);
  // reserved and disabled codes never start the queue
  assign start_req = mode_valid(ctrl_reg.mode) && !q2_empty
                  && (edge_trig || sw_mode)
                  && (!single || ctrl_reg.sse);

  // a word result counts only while running and not being suspended this cycle
  assign conv_taken   = state_reg == Q2_ACTIVE && q2_result.done && !q1_trigger
                     && !mode_change && !stop_mode;
  assign last_word    = q2_result.end_of_queue_code || q2_cmd_ptr == CCW_LAST;
  assign cont_restart = conv_taken && last_word && !single && !q2_empty;
  assign sse_clear    = conv_taken && last_word && single;

  // queue 2 sequencer
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_reg <= Q2_IDLE;
    end else if (stop_mode || mode_change) begin
      state_reg <= Q2_IDLE;
    end else begin
      case (state_reg)
        Q2_IDLE: begin
          if (start_req) begin
            state_reg <= q1_active ? Q2_PENDING : Q2_ACTIVE;
          end
        end
        Q2_PENDING: begin
          if (!q1_active) begin
            state_reg <= Q2_ACTIVE;
          end
        end
        Q2_ACTIVE: begin
          if (q1_trigger) begin
            state_reg <= Q2_SUSPENDED;
          end else if (conv_taken && last_word) begin
            state_reg <= cont_restart ? Q2_ACTIVE : Q2_IDLE;
          end else if (conv_taken && q2_result.pause) begin
            state_reg <= Q2_PAUSED;
          end
        end
        Q2_PAUSED: begin
          if (sw_mode ? retrig_cnt_reg == 2'h1 : edge_trig) begin
            state_reg <= Q2_ACTIVE;
          end
        end
        Q2_SUSPENDED: begin
          if (!q1_active) begin
            state_reg <= Q2_ACTIVE;
          end
        end
        default: begin
          state_reg <= Q2_IDLE;
        end
      endcase
    end
  end

  // software modes leave a pause by themselves after a short retrigger delay
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      retrig_cnt_reg <= '0;
    end else if (conv_taken && q2_result.pause && !last_word) begin
      retrig_cnt_reg <= SW_RETRIG_CYCLES;
    end else if (retrig_cnt_reg != 2'h0) begin
      retrig_cnt_reg <= retrig_cnt_reg - 2'h1;
    end
  end

  // command pointer and subqueue start
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      q2_cmd_ptr    <= '0;
      sub_start_reg <= '0;
    end else if (state_reg == Q2_IDLE && start_req && !mode_change && !stop_mode) begin
      // pointer is sampled here; later writes wait for the next start
      q2_cmd_ptr    <= ctrl_reg.start_ptr;
      sub_start_reg <= ctrl_reg.start_ptr;
    end else if (cont_restart) begin
      q2_cmd_ptr    <= ctrl_reg.start_ptr;
      sub_start_reg <= ctrl_reg.start_ptr;
    end else if (conv_taken && q2_result.pause && !last_word) begin
      q2_cmd_ptr    <= q2_cmd_ptr + 7'h1;
      sub_start_reg <= q2_cmd_ptr + 7'h1;
    end else if (conv_taken && !last_word) begin
      q2_cmd_ptr    <= q2_cmd_ptr + 7'h1;
    end else if (state_reg == Q2_SUSPENDED && !q1_active && !stop_mode && !mode_change) begin
      q2_cmd_ptr    <= resume_lat_reg ? q2_cmd_ptr : sub_start_reg;
    end
  end

  // resume choice is frozen while the queue runs
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      resume_lat_reg <= 1'b0;
    end else if (stop_mode) begin
      resume_lat_reg <= CTRL_RESET[CTRL_RESUME_BIT];
    end else if (mode_change) begin
      resume_lat_reg <= wr_val.resume;
    end else if ((state_reg == Q2_IDLE && start_req) || (conv_taken && last_word)) begin
      resume_lat_reg <= ctrl_reg.resume;
    end
  end

  // interrupt requests, one cycle each
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      q2_complete_irq <= 1'b0;
      q2_pause_irq    <= 1'b0;
    end else begin
      q2_complete_irq <= conv_taken && last_word && ctrl_reg.cie;
      q2_pause_irq    <= conv_taken && q2_result.pause && ctrl_reg.pie;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      q2_run <= 1'b0;
    end else begin
      q2_run <= state_reg == Q2_ACTIVE && !q1_trigger;
    end
  end

  // queue 1 ends against the live pointer; software is better served by an
  // end-of-queue word since a moved pointer can be stepped past
  q1_boundary u_q1_boundary (
    .clk          (clk),
    .rst_n        (rst_n),
    .q1_fetch     (q1_fetch),
    .q1_fetch_loc (q1_fetch_loc),
    .start_ptr    (ctrl_reg.start_ptr),
    .q1_conv_done (q1_conv_done),
    .q1_end       (q1_end),
    .q1_abort     (q1_abort)
  );
endmodule : adc_q2_control

// file: core/q1_boundary.sv
// end-of-queue detection for queue 1 against the queue 2 start pointer
// assumes one fetch pulse per queue 1 word and one done pulse per conversion
`timescale 1ns/10ps
module q1_boundary
  import adc_q2_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       rst_n,
  input  wire logic       q1_fetch,
  input  wire logic [6:0] q1_fetch_loc,
  input  wire logic [6:0] start_ptr,
  input  wire logic       q1_conv_done,
  output logic            q1_end,
  output logic            q1_abort
);
  logic busy_reg;
  logic end_after_reg;
  logic fetch_hit;
  logic fetch_last;

  // live pointer, compared only at fetch so a word in conversion always finishes
  assign fetch_hit  = q1_fetch && !start_ptr[6] && q1_fetch_loc == start_ptr;
  assign fetch_last = q1_fetch && start_ptr[6] && q1_fetch_loc == CCW_LAST;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      busy_reg <= 1'b0;
    end else if (q1_fetch && !fetch_hit) begin
      busy_reg <= 1'b1;
    end else if (q1_conv_done) begin
      busy_reg <= 1'b0;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      end_after_reg <= 1'b0;
    end else if ((fetch_hit && busy_reg) || fetch_last) begin
      end_after_reg <= 1'b1;
    end else if (q1_conv_done) begin
      end_after_reg <= 1'b0;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      q1_end   <= 1'b0;
      q1_abort <= 1'b0;
    end else begin
      q1_end   <= q1_conv_done && end_after_reg;
      q1_abort <= fetch_hit && !busy_reg;
    end
  end
endmodule : q1_boundary

// file: core/q2_interval_timer.sv
// interval and periodic trigger source for queue 2
// assumes the converter clock is clk; restart pulses on every mode change
`timescale 1ns/10ps
module q2_interval_timer
  import adc_q2_pkg::*;
#(
  parameter int EXP_BASE = TIMER_EXP_MIN
) (
  input  wire logic       clk,
  input  wire logic       rst_n,
  input  wire logic [4:0] mode,
  input  wire logic       restart,
  output logic            tick
);
  logic [TIMER_EXP_MAX-1:0] cnt_reg;
  logic [TIMER_EXP_MAX-1:0] mask;
  logic [4:0]               exp_sel;

  // period is the converter clock times two to the selected exponent
  assign exp_sel = 5'(EXP_BASE) + {1'b0, mode[3:0] - MODE_LOW_TMR_LO};
  assign mask    = (TIMER_EXP_MAX'(1) << exp_sel) - TIMER_EXP_MAX'(1);

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_reg <= '0;
    end else if (restart) begin
      cnt_reg <= '0;
    end else begin
      cnt_reg <= cnt_reg + TIMER_EXP_MAX'(1);
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      tick <= 1'b0;
    end else begin
      tick <= mode_timer(mode) && !restart && ((cnt_reg & mask) == mask);
    end
  end
endmodule : q2_interval_timer

// file: shared/adc_q2_pkg.sv
// constants, field layouts and types for the queue 2 control block
// assumes one converter clock drives all users of this package
package adc_q2_pkg;
  // register indices on the plain register port
  localparam logic [3:0]  ADDR_Q2_CTRL     = 4'h0;
  localparam logic [3:0]  ADDR_Q2_STATUS   = 4'h1;
  // control register layout and reset value
  localparam int          CTRL_CIE_BIT     = 15;
  localparam int          CTRL_PIE_BIT     = 14;
  localparam int          CTRL_SSE_BIT     = 13;
  localparam int          CTRL_MODE_HI     = 12;
  localparam int          CTRL_MODE_LO     = 8;
  localparam int          CTRL_RESUME_BIT  = 7;
  localparam int          CTRL_PTR_HI      = 6;
  localparam logic [15:0] CTRL_RESET       = 16'h007F;
  // status register layout
  localparam int          STAT_STATE_LO    = 8;
  localparam int          STAT_PTR_LO      = 0;
  // mode codes, low nibble classes and reserved codes
  localparam int          MODE_CONT_BIT    = 4;
  localparam logic [4:0]  MODE_DISABLED    = 5'h00;
  localparam logic [4:0]  MODE_RSVD_A      = 5'h0F;
  localparam logic [4:0]  MODE_RSVD_B      = 5'h10;
  localparam logic [4:0]  MODE_RSVD_C      = 5'h1F;
  localparam logic [3:0]  MODE_LOW_SW      = 4'h1;
  localparam logic [3:0]  MODE_LOW_RISE    = 4'h2;
  localparam logic [3:0]  MODE_LOW_FALL    = 4'h3;
  localparam logic [3:0]  MODE_LOW_TMR_LO  = 4'h4;
  localparam logic [3:0]  MODE_LOW_TMR_HI  = 4'hE;
  // timer period exponents and command table limits
  localparam int          TIMER_EXP_MIN    = 7;
  localparam int          TIMER_EXP_MAX    = 17;
  localparam logic [6:0]  CCW_LAST         = 7'h3F;
  localparam logic [1:0]  SW_RETRIG_CYCLES = 2'h2;

  typedef struct packed {
    logic       cie;
    logic       pie;
    logic       sse;
    logic [4:0] mode;
    logic       resume;
    logic [6:0] start_ptr;
  } q2_ctrl_t;

  typedef struct packed {
    logic done;
    logic pause;
    logic end_of_queue_code;
  } conv_result_t;

  typedef enum logic [2:0] {Q2_IDLE, Q2_PENDING, Q2_ACTIVE, Q2_PAUSED, Q2_SUSPENDED} q2_state_t;

  function automatic logic mode_valid(input logic [4:0] m);
    return m != MODE_DISABLED && m != MODE_RSVD_A && m != MODE_RSVD_B && m != MODE_RSVD_C;
  endfunction : mode_valid

  function automatic logic mode_timer(input logic [4:0] m);
    return m[3:0] >= MODE_LOW_TMR_LO && m[3:0] <= MODE_LOW_TMR_HI;
  endfunction : mode_timer
endpackage : adc_q2_pkg

// file: verification/adc_q2_control_props.sv
// concurrent checks on the queue 2 control block ports
// assumes one converter clock and the active-low asynchronous reset
`timescale 1ns/10ps
module adc_q2_control_props
  import adc_q2_pkg::*;
(
  input wire logic         clk,
  input wire logic         rst_n,
  input wire logic         stop_mode,
  input wire logic         test_mode,
  input wire logic [3:0]   reg_addr,
  input wire logic         reg_rd,
  input wire logic         reg_wr,
  input wire logic [15:0]  reg_rdata,
  input wire logic         q1_trigger,
  input wire logic         q1_fetch,
  input wire logic         q1_conv_done,
  input wire conv_result_t q2_result,
  input wire logic         q2_run,
  input wire logic [6:0]   q2_cmd_ptr,
  input wire logic         q2_complete_irq,
  input wire logic         q2_pause_irq,
  input wire logic         q1_end,
  input wire logic         q1_abort
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  property p_sse; reg_rd && reg_addr == ADDR_Q2_CTRL && !test_mode |=> !reg_rdata[CTRL_SSE_BIT]; endproperty
  a_sse: assert property (p_sse) else $error("single-scan enable visible outside test mode");
  property p_stop; $past(stop_mode) && stop_mode && reg_rd && reg_addr == ADDR_Q2_CTRL |=> reg_rdata == CTRL_RESET;
  endproperty
  a_stop: assert property (p_stop) else $error("control not at reset value in stop");
  // a trigger may land one cycle before the suspension shows on the run flag
  property p_susp; q1_trigger |-> ##[1:2] !q2_run; endproperty
  a_susp: assert property (p_susp) else $error("queue 2 still running after suspend");
  property p_abort; q1_abort |-> $past(q1_fetch); endproperty
  a_abort: assert property (p_abort) else $error("abort without a fetch");
  property p_end; q1_end |-> $past(q1_conv_done); endproperty
  a_end: assert property (p_end) else $error("queue 1 end without a finished conversion");
  property p_cirq; q2_complete_irq |-> $past(q2_result.done) && ($past(q2_result.end_of_queue_code) || $past(q2_cmd_ptr) == CCW_LAST);
  endproperty
  a_cirq: assert property (p_cirq) else $error("completion request without last word");
  property p_pirq; q2_pause_irq |-> $past(q2_result.done) && $past(q2_result.pause); endproperty
  a_pirq: assert property (p_pirq) else $error("pause request without paused word");
  property p_ptr; q2_run && q2_result.done && !q2_result.end_of_queue_code && q2_cmd_ptr != CCW_LAST && !q1_trigger && !reg_wr
    && !stop_mode |=> q2_cmd_ptr == $past(q2_cmd_ptr) + 7'h01; endproperty
  a_ptr: assert property (p_ptr) else $error("word pointer did not advance");
endmodule : adc_q2_control_props

bind adc_q2_control adc_q2_control_props u_props (.clk(clk), .rst_n(rst_n), .stop_mode(stop_mode),
  .test_mode(test_mode), .reg_addr(reg_addr), .reg_rd(reg_rd), .reg_wr(reg_wr), .reg_rdata(reg_rdata),
  .q1_trigger(q1_trigger), .q1_fetch(q1_fetch), .q1_conv_done(q1_conv_done), .q2_result(q2_result),
  .q2_run(q2_run), .q2_cmd_ptr(q2_cmd_ptr), .q2_complete_irq(q2_complete_irq),
  .q2_pause_irq(q2_pause_irq), .q1_end(q1_end), .q1_abort(q1_abort));

// file: verification/adc_q2_control_tb.sv
// self-checking bench for the queue 2 control block
// assumes the checker is bound by its own file; timer base shortened to 2
`timescale 1ns/10ps
module adc_q2_control_tb
  import adc_q2_pkg::*;
;
  logic         clk, rst_n, stop_mode, test_mode, reg_wr, reg_rd, ext_trigger_pin;
  logic         q1_trigger, q1_active, q1_fetch, q1_conv_done;
  logic [3:0]   reg_addr;
  logic [15:0]  reg_wdata, reg_rdata;
  logic [6:0]   q1_fetch_loc, q2_cmd_ptr;
  conv_result_t q2_result;
  logic         q2_run, q2_complete_irq, q2_pause_irq, q1_end, q1_abort;
  int           mismatches, tests_run;
  logic [32:0]  rows [6];

  adc_q2_control #(.TIMER_EXP_BASE(2)) dut (.clk(clk), .rst_n(rst_n), .stop_mode(stop_mode),
    .test_mode(test_mode), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .ext_trigger_pin(ext_trigger_pin), .q1_trigger(q1_trigger), .q1_active(q1_active),
    .q1_fetch(q1_fetch), .q1_fetch_loc(q1_fetch_loc), .q1_conv_done(q1_conv_done), .q2_result(q2_result),
    .q2_run(q2_run), .q2_cmd_ptr(q2_cmd_ptr), .q2_complete_irq(q2_complete_irq),
    .q2_pause_irq(q2_pause_irq), .q1_end(q1_end), .q1_abort(q1_abort));

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    tests_run++;
    if (got !== exp) begin
      mismatches++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic chkb(input logic got, input logic exp);
    chk({15'h0000, got}, {15'h0000, exp});
  endtask : chkb

  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge clk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge clk);
    reg_wr    <= 1'b0;
  endtask : wr

  task automatic rd(input logic [3:0] a, input logic [15:0] exp);
    @(posedge clk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge clk);
    reg_rd   <= 1'b0;
    @(negedge clk);
    chk(reg_rdata, exp);
  endtask : rd

  task automatic done(input logic p, input logic e, input logic pi, input logic ci);
    @(posedge clk);
    q2_result <= '{1'b1, p, e};
    @(posedge clk);
    q2_result <= '0;
    @(negedge clk);
    chkb(q2_pause_irq, pi);
    chkb(q2_complete_irq, ci);
  endtask : done

  // the run flag lags the state by a cycle, so let a pause settle first
  task automatic wait_ptr(input logic [6:0] p);
    int n = 0;
    repeat (4) @(negedge clk);
    while (!(q2_run === 1'b1 && q2_cmd_ptr === p) && n < 60) begin
      @(negedge clk);
      n++;
    end
    chkb(q2_run, 1'b1);
    chk({9'h000, q2_cmd_ptr}, {9'h000, p});
  endtask : wait_ptr

  task automatic susp(input logic [6:0] p);
    @(posedge clk);
    q1_trigger <= 1'b1;
    q1_active  <= 1'b1;
    @(posedge clk);
    q1_trigger <= 1'b0;
    repeat (2) @(posedge clk);
    q1_active  <= 1'b0;
    @(negedge clk);
    chkb(q2_run, 1'b0);
    wait_ptr(p);
  endtask : susp

  task automatic q1p(input logic f, input logic [6:0] loc);
    @(posedge clk);
    q1_fetch     <= f;
    q1_conv_done <= !f;
    q1_fetch_loc <= loc;
    @(posedge clk);
    {q1_fetch, q1_conv_done} <= 2'h0;
    @(negedge clk);
  endtask : q1p

  task automatic stp;
    @(posedge clk);
    stop_mode <= 1'b1;
    @(posedge clk);
    rd(ADDR_Q2_CTRL, CTRL_RESET);
    chkb(q2_run, 1'b0);
    @(posedge clk);
    stop_mode <= 1'b0;
  endtask : stp

  task automatic test_done;
    if (mismatches == 0 && tests_run > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : test_done

  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  initial begin
    repeat (5000) @(posedge clk);
    mismatches++;
    test_done();
  end

  initial begin
    {rst_n, stop_mode, test_mode, reg_wr, reg_rd, ext_trigger_pin, q1_trigger, q1_active} = '0;
    {q1_fetch, q1_conv_done, reg_addr, reg_wdata, q1_fetch_loc, q2_result} = '0;
    {mismatches, tests_run} = '0;
    rows = '{{1'b0, 16'h0000, 16'h0000}, {1'b0, 16'hFFFF, 16'hDFFF}, {1'b1, 16'h2000, 16'h2000},
             {1'b1, 16'h2F01, 16'h2F01}, {1'b1, 16'h3001, 16'h3001}, {1'b0, 16'h9F40, 16'h9F40}};
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    rd(ADDR_Q2_CTRL, CTRL_RESET);
    rd(ADDR_Q2_STATUS, 16'h0000);
    // reserved and disabled codes must never start the queue
    foreach (rows[i]) begin
      @(posedge clk);
      test_mode <= rows[i][32];
      wr(ADDR_Q2_CTRL, rows[i][31:16]);
      rd(ADDR_Q2_CTRL, rows[i][15:0]);
      chkb(q2_run, 1'b0);
    end
    @(posedge clk);
    test_mode <= 1'b0;
    wr(4'h5, 16'hFFFF);
    rd(4'h5, 16'h0000);
    rd(ADDR_Q2_CTRL, 16'h9F40);
    stp();
    wr(ADDR_Q2_CTRL, 16'hE107);
    wait_ptr(7'h07);
    done(1'b0, 1'b0, 1'b0, 1'b0);
    susp(7'h07);
    done(1'b1, 1'b0, 1'b1, 1'b0);
    wait_ptr(7'h08);
    done(1'b0, 1'b0, 1'b0, 1'b0);
    susp(7'h08);
    done(1'b0, 1'b1, 1'b0, 1'b1);
    @(posedge clk);
    test_mode <= 1'b1;
    rd(ADDR_Q2_CTRL, 16'hC107);
    @(posedge clk);
    test_mode <= 1'b0;
    stp();
    wr(ADDR_Q2_CTRL, 16'h9185);
    wait_ptr(7'h05);
    done(1'b0, 1'b0, 1'b0, 1'b0);
    susp(7'h06);
    wr(ADDR_Q2_CTRL, 16'h9189);
    @(negedge clk);
    chk({9'h000, q2_cmd_ptr}, 16'h0006);
    done(1'b0, 1'b1, 1'b0, 1'b1);
    wait_ptr(7'h09);
    stp();
    wr(ADDR_Q2_CTRL, 16'h1403);
    wait_ptr(7'h03);
    stp();
    wr(ADDR_Q2_CTRL, 16'h0202);
    ext_trigger_pin <= 1'b1;
    repeat (10) @(negedge clk);
    chkb(q2_run, 1'b0);
    @(posedge clk);
    ext_trigger_pin <= 1'b0;
    wr(ADDR_Q2_CTRL, 16'h2202);
    repeat (6) @(posedge clk);
    ext_trigger_pin <= 1'b1;
    wait_ptr(7'h02);
    stp();
    wr(ADDR_Q2_CTRL, 16'h0000);
    q1p(1'b1, 7'h00);
    chkb(q1_abort, 1'b1);
    wr(ADDR_Q2_CTRL, 16'h0040);
    q1p(1'b1, 7'h3F);
    q1p(1'b0, 7'h3F);
    chkb(q1_end, 1'b1);
    wr(ADDR_Q2_CTRL, 16'h0010);
    q1p(1'b1, 7'h02);
    wr(ADDR_Q2_CTRL, 16'h0003);
    q1p(1'b1, 7'h03);
    chkb(q1_abort, 1'b0);
    q1p(1'b0, 7'h03);
    chkb(q1_end, 1'b1);
    test_done();
  end
endmodule : adc_q2_control_tb
